// *** rtl/isdnl_pkg.sv ***
// constants and carrier types for the inter-chip link slave
// Summary of operation
// R1 - basic frame: B1, B2, D in 20 bits
// R2 - pure link slave, separate rx and tx
// R3 - two independent links, own clock and sync
// R4 - clocks after sync pulse start new frame
// R5 - receive only bits enabled by route entries
// R6 - drive tx only on enabled bits, else hi-z
// R7 - bearers 64 kbps each, signalling 16 kbps
// R8 - 8 and 10 bit layouts via entries only
// R9 - any bit routes to controller or strobe
// R10 - request asserted while signalling data waits
// R11 - master grants when signalling channel free
// R12 - grant sampled only at frame sync
// R13 - granted frame: flag zero in first D bit
// R14 - grant drop halts; controller retries whole frame
// R15 - primary rate: four byte channels, shared streams
// R16 - per-bit acceptance and routing for rate adaptation
// R17 - data one bit after sync, edge rules
// R18 - grant from tx sync pin to controller
// R19 - unused entries hold 0001, no routing
// R20 - rx section at 0, tx at 128
// R21 - grant mode enable, grant routed to controller
// R22 - common timing feeds rx clock/sync to tx
// R23 - request drops when controller has nothing pending
// R24 - no grant: signalling bits stay hi-z
package isdnl_pkg;
    localparam int NUM_PORTS = 2;
    localparam int ROUTE_ENTRIES = 16;
    localparam int IDX_W = 6;
    localparam int ADDR_W = 12;
    localparam int BASIC_FRAME_BITS = 20;
    localparam int BEARER_KBPS = 64;
    localparam int SIGNAL_KBPS = 16;
    // route entry layout
    localparam logic [15:0] ENTRY_UNUSED = 16'h0001;
    localparam int F_LAST = 0;
    localparam int F_BYTE = 1;
    localparam int F_CNT_LO = 2;
    localparam int F_CHANNEL_SELECT_LO = 6;
    localparam int F_SSEL_LO = 9;
    localparam logic [2:0] CHANNEL_SELECT_NONE = 3'h0;
    localparam logic [2:0] CHANNEL_SELECT_GRANT = 3'h7;
    // register map
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
    localparam logic [1:0] RAM_SEL = 2'h1;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam int PF_W = 8;
    localparam int C_EN = 0;
    localparam int C_GM = 1;
    localparam int C_CRT = 2;
    localparam int C_GR_LO = 3;
    localparam int S_GRANT = 0;
    localparam int S_REQ = 1;
    localparam int S_RXRUN = 2;
    localparam int S_TXRUN = 3;
    localparam int S_IDX_LO = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {WALK_IDLE, WALK_ARMED, WALK_RUN} isdnl_walk_t;
    typedef struct packed {
        isdnl_walk_t state;
        logic [IDX_W-1:0] idx;
        logic [6:0] bitcnt;
    } isdnl_walker_t;
    typedef struct packed {
        logic layer1_rx_clock;
        logic layer1_rx_frame_sync;
        logic layer1_rx_serial_in;
        logic layer1_tx_clock;
        logic layer1_tx_sync_pin;
    } isdnl_link_in_t;
    typedef struct packed {
        logic layer1_tx_serial_out;
        logic layer1_tx_serial_oe;
        logic dchan_tx_request;
        logic [3:0] strobe;
    } isdnl_link_out_t;
    typedef struct packed {
        logic valid;
        logic data;
        logic [2:0] channel;
    } isdnl_rx_bit_t;
    typedef struct packed {
        logic valid;
        logic [2:0] channel;
    } isdnl_tx_req_t;
    typedef struct packed {
        isdnl_link_in_t s1;
        isdnl_link_in_t s2;
        logic rclk_prev;
        logic tclk_prev;
        isdnl_walker_t rx;
        isdnl_walker_t tx;
        logic grant_held;
        logic req;
        logic [3:0] strobe;
        logic txd;
        logic txoe;
        isdnl_rx_bit_t rxbit;
    } isdnl_port_t;
endpackage

// *** rtl/isdnl_link_slave.sv ***
// two-port inter-chip link slave with route entries and axi4-lite registers
module isdnl_link_slave
    import isdnl_pkg::*;
#(
    parameter int ENT = ROUTE_ENTRIES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire isdnl_link_in_t [NUM_PORTS-1:0] link_in,
    output isdnl_link_out_t [NUM_PORTS-1:0] link_out,
    input wire logic [NUM_PORTS-1:0] dchan_pending,
    output isdnl_rx_bit_t [NUM_PORTS-1:0] rx_bit,
    output isdnl_tx_req_t [NUM_PORTS-1:0] tx_req,
    input wire logic [NUM_PORTS-1:0] tx_bit_data,
    output logic [NUM_PORTS-1:0] tx_permit
);
    typedef struct packed {
        isdnl_port_t [NUM_PORTS-1:0] pt;
        logic [NUM_PORTS-1:0][1:0][ENT-1:0][15:0] ram;
        logic [31:0] ctrl;
        logic aw_hold;
        logic [ADDR_W-1:0] awaddr;
        logic w_hold;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } isdnl_state_t;

    isdnl_state_t st;
    isdnl_state_t next_st;
    isdnl_tx_req_t [NUM_PORTS-1:0] next_tx_req;

    // R1 R7 channel widths from entries
    // one step of the entry walker; an entry lasts cnt+1 bits or cnt+1 bytes
    function automatic isdnl_walker_t walk_step(isdnl_walker_t w, logic [15:0] e);
        logic [6:0] len_m1;
        isdnl_walker_t r;
        len_m1 = e[F_BYTE] ? {e[F_CNT_LO +: 4], 3'h7} : {3'h0, e[F_CNT_LO +: 4]};
        r = w;
        if (w.bitcnt != len_m1)
        begin
            r.bitcnt = w.bitcnt + 7'h01;
        end
        else if (e[F_LAST] || w.idx == IDX_W'(ENT - 1))
        begin
            r.state = WALK_IDLE;
        end
        else
        begin
            r.idx = w.idx + 1'b1;
            r.bitcnt = 7'h00;
        end
        return r;
    endfunction

    // a byte address hits the route window when port and index exist
    function automatic logic ram_hit(logic [ADDR_W-1:0] a);
        return a[11:10] == RAM_SEL && int'(a[8]) < NUM_PORTS && int'(a[7:2]) < ENT;
    endfunction

    assign awready = !st.aw_hold && !st.bvalid;
    assign wready = !st.w_hold && !st.bvalid;
    assign arready = !st.rvalid;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign rvalid = st.rvalid;
    assign rresp = st.rresp;
    assign rdata = st.rdata;
    assign tx_req = next_tx_req;

    // pins and controller-side data except tx_req come straight from state flops; tx_req is next-state logic
    always_comb
    begin
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            link_out[p].layer1_tx_serial_out = st.pt[p].txd;
            link_out[p].layer1_tx_serial_oe = st.pt[p].txoe;
            link_out[p].dchan_tx_request = st.pt[p].req;
            link_out[p].strobe = st.pt[p].strobe;
            rx_bit[p] = st.pt[p].rxbit;
            tx_permit[p] = st.pt[p].grant_held;
        end
    end

    // next-state logic: register slave, then each link port
    always_comb
    begin
        logic [7:0] cf;
        logic en;
        logic gm;
        logic crt;
        logic [2:0] gr;
        logic rclk;
        logic tclk;
        logic tsync;
        logic rfall;
        logic tfall;
        logic trise;
        logic drive;
        logic [15:0] e;
        logic [2:0] channel_select;
        isdnl_walker_t w;
        logic [31:0] rd;
        cf = 8'h00;
        en = 1'b0;
        gm = 1'b0;
        crt = 1'b0;
        gr = 3'h0;
        rclk = 1'b0;
        tclk = 1'b0;
        tsync = 1'b0;
        rfall = 1'b0;
        tfall = 1'b0;
        trise = 1'b0;
        drive = 1'b0;
        e = 16'h0000;
        channel_select = 3'h0;
        w = '0;
        rd = 32'h00000000;
        next_st = st;
        next_tx_req = '0;

        // write channel: address and data taken in either order
        if (awvalid && awready)
        begin
            next_st.aw_hold = 1'b1;
            next_st.awaddr = awaddr;
        end
        if (wvalid && wready)
        begin
            next_st.w_hold = 1'b1;
            next_st.wdata = wdata;
            next_st.wstrb = wstrb;
        end
        if (st.aw_hold && st.w_hold)
        begin
            next_st.aw_hold = 1'b0;
            next_st.w_hold = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            if (st.awaddr == ADDR_CTRL)
            begin
                for (int b = 0; b < 4; b++)
                begin
                    if (st.wstrb[b])
                    begin
                        next_st.ctrl[b*8 +: 8] = st.wdata[b*8 +: 8];
                    end
                end
            end
            // R20 rx/tx sections
            else if (ram_hit(st.awaddr))
            begin
                for (int b = 0; b < 2; b++)
                begin
                    if (st.wstrb[b])
                    begin
                        next_st.ram[st.awaddr[8]][st.awaddr[9]][st.awaddr[7:2]][b*8 +: 8] = st.wdata[b*8 +: 8];
                    end
                end
            end
            else if (st.awaddr != ADDR_STATUS)
            begin
                next_st.bresp = RESP_SLVERR;
            end
        end
        if (st.bvalid && bready)
        begin
            next_st.bvalid = 1'b0;
        end

        // read channel: answer one cycle after the address is taken
        if (arvalid && arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            if (araddr == ADDR_CTRL)
            begin
                rd = st.ctrl;
            end
            else if (araddr == ADDR_STATUS)
            begin
                for (int p = 0; p < NUM_PORTS; p++)
                begin
                    rd[p*PF_W + S_GRANT] = st.pt[p].grant_held;
                    rd[p*PF_W + S_REQ] = st.pt[p].req;
                    rd[p*PF_W + S_RXRUN] = st.pt[p].rx.state == WALK_RUN;
                    rd[p*PF_W + S_TXRUN] = st.pt[p].tx.state == WALK_RUN;
                    rd[p*PF_W + S_IDX_LO +: 4] = st.pt[p].rx.idx[3:0];
                end
            end
            else if (ram_hit(araddr))
            begin
                rd = {16'h0000, st.ram[araddr[8]][araddr[9]][araddr[7:2]]};
            end
            else
            begin
                next_st.rresp = RESP_SLVERR;
            end
            next_st.rdata = rd;
        end
        if (st.rvalid && rready)
        begin
            next_st.rvalid = 1'b0;
        end

        // R3 independent ports
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            cf = st.ctrl[p*PF_W +: PF_W];
            en = cf[C_EN];
            gm = cf[C_GM];
            crt = cf[C_CRT];
            gr = cf[C_GR_LO +: 3];
            // two flops on every pin before any logic looks at it
            next_st.pt[p].s1 = link_in[p];
            next_st.pt[p].s2 = st.pt[p].s1;
            rclk = st.pt[p].s2.layer1_rx_clock;
            // R22 shared timing
            tclk = crt ? rclk : st.pt[p].s2.layer1_tx_clock;
            // the tx sync pin carries the grant in grant mode, so tx framing follows rx sync
            tsync = (crt || gm) ? st.pt[p].s2.layer1_rx_frame_sync : st.pt[p].s2.layer1_tx_sync_pin;
            next_st.pt[p].rclk_prev = rclk;
            next_st.pt[p].tclk_prev = tclk;
            rfall = st.pt[p].rclk_prev && !rclk;
            tfall = st.pt[p].tclk_prev && !tclk;
            trise = !st.pt[p].tclk_prev && tclk;
            next_st.pt[p].rxbit.valid = 1'b0;
            // R10 R23 request follows pending work
            next_st.pt[p].req = en && gm && dchan_pending[p];
            if (!en)
            begin
                next_st.pt[p].rx.state = WALK_IDLE;
                next_st.pt[p].tx.state = WALK_IDLE;
                next_st.pt[p].txoe = 1'b0;
                next_st.pt[p].strobe = 4'h0;
            end
            else
            begin
                // R2 R4 R17 sync sampled on falling edge
                if (rfall && st.pt[p].s2.layer1_rx_frame_sync)
                begin
                    next_st.pt[p].rx = '{state: WALK_RUN, idx: '0, bitcnt: 7'h00};
                    // R12 R18 R21 grant taken at sync only
                    next_st.pt[p].grant_held = gm ? st.pt[p].s2.layer1_tx_sync_pin : 1'b1;
                end
                else if (rfall && st.pt[p].rx.state == WALK_RUN)
                begin
                    e = st.ram[p][0][st.pt[p].rx.idx];
                    channel_select = e[F_CHANNEL_SELECT_LO +: 3];
                    // R5 R9 R16 R19 only routed bits are taken
                    if (channel_select != CHANNEL_SELECT_NONE && channel_select != CHANNEL_SELECT_GRANT)
                    begin
                        next_st.pt[p].rxbit = '{valid: 1'b1, data: st.pt[p].s2.layer1_rx_serial_in, channel: channel_select};
                    end
                    next_st.pt[p].rx = walk_step(st.pt[p].rx, e);
                end
                // R9 strobes follow the active receive entry
                if (next_st.pt[p].rx.state == WALK_RUN)
                begin
                    next_st.pt[p].strobe = st.ram[p][0][next_st.pt[p].rx.idx][F_SSEL_LO +: 4];
                end
                else
                begin
                    next_st.pt[p].strobe = 4'h0;
                end
                if (tfall && tsync)
                begin
                    next_st.pt[p].tx.state = WALK_ARMED;
                end
                // R17 tx changes on rising edge, bit 0 one bit after sync
                if (trise)
                begin
                    w = st.pt[p].tx;
                    if (w.state == WALK_ARMED)
                    begin
                        w = '{state: WALK_RUN, idx: '0, bitcnt: 7'h00};
                    end
                    else if (w.state == WALK_RUN)
                    begin
                        w = walk_step(w, st.ram[p][1][w.idx]);
                    end
                    next_st.pt[p].tx = w;
                    drive = 1'b0;
                    if (w.state == WALK_RUN)
                    begin
                        e = st.ram[p][1][w.idx];
                        channel_select = e[F_CHANNEL_SELECT_LO +: 3];
                        // R24 R13 R14 no grant holds signalling bits off the line
                        drive = channel_select != CHANNEL_SELECT_NONE && channel_select != CHANNEL_SELECT_GRANT && !(gm && channel_select == gr && !st.pt[p].grant_held);
                    end
                    // R6 R8 R15 drive only routed bits
                    next_st.pt[p].txoe = drive;
                    next_tx_req[p] = '{valid: drive, channel: channel_select};
                    if (drive)
                    begin
                        next_st.pt[p].txd = tx_bit_data[p];
                    end
                end
            end
        end
    end

    // single state register; route entries come up as unused
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= '0;
            st.ctrl <= CTRL_RESET;
            // R19 unused entry value
            st.ram <= {(NUM_PORTS*2*ENT){ENTRY_UNUSED}};
        end
        else
        begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // per-port checks
    for (genvar g = 0; g < NUM_PORTS; g++)
    begin : g_chk
        sequence frame_sync_seen;
            st.pt[g].rclk_prev && !st.pt[g].s2.layer1_rx_clock && st.pt[g].s2.layer1_rx_frame_sync
                && st.ctrl[g*PF_W + C_EN];
        endsequence
        sequence tx_leaves_armed;
            st.ctrl[g*PF_W + C_EN] && st.pt[g].tx.state == WALK_ARMED ##1 st.pt[g].tx.state != WALK_ARMED
                && st.ctrl[g*PF_W + C_EN];
        endsequence
        property frame_start_p;
            frame_sync_seen |=> st.pt[g].rx.state == WALK_RUN && st.pt[g].rx.idx == '0 && st.pt[g].rx.bitcnt == 7'h00;
        endproperty
        frame_start_a: assert property (frame_start_p) else $error("frame did not restart at sync"); // R4
        grant_sample_a: assert property (frame_sync_seen ##0 st.ctrl[g*PF_W + C_GM]
            |=> tx_permit[g] == $past(st.pt[g].s2.layer1_tx_sync_pin)) else $error("grant not taken at sync"); // R12
        grant_stable_a: assert property (!(st.pt[g].rclk_prev && !st.pt[g].s2.layer1_rx_clock
            && st.pt[g].s2.layer1_rx_frame_sync) |=> $stable(tx_permit[g])) else $error("grant moved mid-frame"); // R12
        tx_hiz_a: assert property (link_out[g].layer1_tx_serial_oe |-> st.pt[g].tx.state == WALK_RUN)
            else $error("tx driven outside frame"); // R6
        dchan_inhibit_a: assert property (tx_req[g].valid && st.ctrl[g*PF_W + C_GM]
            && tx_req[g].channel == st.ctrl[g*PF_W + C_GR_LO +: 3] |-> st.pt[g].grant_held)
            else $error("signalling bit sent without grant"); // R24
        rx_ignore_a: assert property (rx_bit[g].valid |-> $past(st.pt[g].rx.state) == WALK_RUN
            && rx_bit[g].channel != CHANNEL_SELECT_NONE) else $error("unrouted bit taken"); // R5
        req_raise_a: assert property (dchan_pending[g] && st.ctrl[g*PF_W + C_EN] && st.ctrl[g*PF_W + C_GM]
            |=> link_out[g].dchan_tx_request) else $error("request not raised"); // R10
        req_drop_a: assert property (!dchan_pending[g] |=> !link_out[g].dchan_tx_request)
            else $error("request held while idle"); // R23
        tx_start_a: assert property (tx_leaves_armed |-> st.pt[g].tx.state == WALK_RUN
            && st.pt[g].tx.idx == '0 && st.pt[g].tx.bitcnt == 7'h00) else $error("tx frame start wrong"); // R17
    end
endmodule

// *** test/isdnl_phy_model.sv ***
// physical layer master model driving one link port
module isdnl_phy_model
    import isdnl_pkg::*;
#(
    parameter bit GRANT_PIN = 1'h0
)
(
    output isdnl_link_in_t pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // clocks stand still low between frames
    initial
    begin
        pins = '0;
    end

    // sync period, then data changing on rising edges
    task automatic send_frame(input logic [31:0] bits, input int n, input logic grant, input int flip);
        for (int k = -1; k < n; k++)
        begin
            pins.layer1_rx_clock = 1'h1;
            // tx clock left idle where tx must follow rx timing
            pins.layer1_tx_clock = !GRANT_PIN;
            pins.layer1_rx_frame_sync = (k == -1);
            pins.layer1_rx_serial_in = (k < 0) ? !bits[0] : bits[k];
            pins.layer1_tx_sync_pin = GRANT_PIN ? (grant ^ (k >= flip)) : (k == -1);
            #80;
            pins.layer1_rx_clock = 1'h0;
            pins.layer1_tx_clock = 1'h0;
            #80;
        end
        // released data keeps moving so a stale sample cannot match
        pins.layer1_rx_serial_in = !pins.layer1_rx_serial_in;
    endtask
endmodule

// *** test/tb_top.sv ***
// self-checking bench for the two-port link slave
module tb_top
    import isdnl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    isdnl_link_in_t pins0, pins1;
    isdnl_link_in_t [NUM_PORTS-1:0] link_in;
    isdnl_link_out_t [NUM_PORTS-1:0] link_out;
    logic [NUM_PORTS-1:0] dchan_pending = '0, tx_bit_data = '0, tx_permit;
    isdnl_rx_bit_t [NUM_PORTS-1:0] rx_bit;
    isdnl_tx_req_t [NUM_PORTS-1:0] tx_req;
    int n_fail = 0, checks = 0;
    int tx_cnt[2];
    logic strobe_seen[2];
    logic glow = 1'h0;
    logic [33:0] rd_q[$];
    logic [1:0] wr_q[$];
    logic [3:0] rx_q[2][$];
    logic [3:0] tx_q[2][$];
    // route plan per port: bits and controller of each entry
    int rlen[2][5] = '{'{8, 1, 1, 8, 1}, '{4, 8, 1, 0, 0}};
    logic [2:0] rch[2][5] = '{'{3'h2, 3'h1, 3'h0, 3'h4, 3'h1}, '{3'h3, 3'h5, 3'h7, 3'h0, 3'h0}};
    logic [15:0] rent[2][5] = '{'{16'h0082, 16'h0040, 16'h0000, 16'h0102, 16'h0241},
        '{16'h00CC, 16'h0142, 16'h01C1, 16'h0001, 16'h0001}};

    assign link_in = {pins1, pins0};

    isdnl_link_slave u_isdnl_link_slave (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .link_in(link_in),
        .link_out(link_out), .dchan_pending(dchan_pending), .rx_bit(rx_bit), .tx_req(tx_req),
        .tx_bit_data(tx_bit_data), .tx_permit(tx_permit));
    isdnl_phy_model #(.GRANT_PIN(1'h1)) u_isdnl_phy_model0 (.pins(pins0));
    isdnl_phy_model #(.GRANT_PIN(1'h0)) u_isdnl_phy_model1 (.pins(pins1));

    // free-running system clock
    initial
    begin
        forever #10 aclk = ~aclk;
    end

    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        int n;
        wr_q.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (awready === 1'h1)
                awvalid <= 1'h0;
            if (wready === 1'h1)
                wvalid <= 1'h0;
            n++;
        end
        while (bvalid !== 1'h1 && n < 50);
        bready <= 1'h0;
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [33:0] e);
        int n;
        rd_q.push_back(e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (arready === 1'h1)
                arvalid <= 1'h0;
            n++;
        end
        while (rvalid !== 1'h1 && n < 50);
        rready <= 1'h0;
    endtask

    // result watcher: pops the oldest note whenever a response or rx bit shows; tx requests are queued for tx_watch
    always @(posedge aclk)
    begin
        if (bvalid === 1'h1 && bready === 1'h1 && wr_q.size() > 0)
            cmp(bresp, wr_q.pop_front());
        if (rvalid === 1'h1 && rready === 1'h1 && rd_q.size() > 0)
            cmp({rresp, rdata}, rd_q.pop_front());
        for (int p = 0; p < 2; p++)
        begin
            if (rx_bit[p].valid === 1'h1)
                cmp({rx_bit[p].data, rx_bit[p].channel}, rx_q[p].size() ? rx_q[p].pop_front() : 5'h10);
            if (tx_req[p].valid === 1'h1)
            begin
                tx_q[p].push_back({tx_bit_data[p], tx_req[p].channel});
                tx_bit_data[p] <= 1'($urandom);
            end
            if (link_out[p].strobe[0] === 1'h1)
                strobe_seen[p] = 1'h1;
        end
    end

    // pin sampled late in each bit, since the tx pin trails the link edge
    task automatic tx_watch(input int p);
        forever
        begin
            @(negedge link_in[p].layer1_rx_clock);
            #75;
            if (link_out[p].layer1_tx_serial_oe === 1'h1)
            begin
                tx_cnt[p]++;
                while (tx_q[p].size() > 0 && (tx_q[p][0][2:0] inside {3'h0, 3'h7} ||
                    (p == 0 && glow && tx_q[p][0][2:0] == 3'h1)))
                    void'(tx_q[p].pop_front());
                cmp(link_out[p].layer1_tx_serial_out, tx_q[p].size() ? tx_q[p].pop_front() >> 3 : 2'h2);
            end
        end
    endtask

    initial
    begin
        fork
            tx_watch(0);
            tx_watch(1);
        join
    end

    // one frame on a port: expectations first, then the master sends it
    task automatic frame(input int p, input logic grant, input int flip);
        logic [31:0] bits;
        int k, n;
        bits = $urandom;
        k = 0;
        n = 0;
        for (int e = 0; e < 5; e++)
            for (int b = 0; b < rlen[p][e]; b++)
            begin
                if (!(rch[p][e] inside {CHANNEL_SELECT_NONE, CHANNEL_SELECT_GRANT}))
                    rx_q[p].push_back({bits[k], rch[p][e]});
                if (!(rch[p][e] inside {CHANNEL_SELECT_NONE, CHANNEL_SELECT_GRANT}) && !(p == 0 && !grant && rch[p][e] == 3'h1))
                    n++;
                k++;
            end
        tx_cnt[p] = 0;
        strobe_seen[p] = 1'h0;
        if (p == 0)
        begin
            glow = !grant;
            // spare trailing bits must be neither taken nor driven
            u_isdnl_phy_model0.send_frame(bits, BASIC_FRAME_BITS, grant, flip);
        end
        else
            u_isdnl_phy_model1.send_frame(bits, k + 1, grant, flip);
        #100;
        cmp(rx_q[p].size(), 0);
        cmp(tx_cnt[p], n);
        cmp(tx_permit[p], p ? 1'h1 : grant);
        cmp(strobe_seen[p], p ? 1'h0 : 1'h1);
    endtask

    initial
    begin
        void'($urandom(47507));
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        axi_rd(ADDR_CTRL, {RESP_OKAY, CTRL_RESET});
        axi_rd(12'h400, {RESP_OKAY, 32'h00000001});
        axi_rd(12'h100, {RESP_SLVERR, 32'h00000000});
        axi_wr(12'h100, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
        axi_wr(ADDR_STATUS, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        axi_rd(ADDR_CTRL, {RESP_OKAY, CTRL_RESET});
        $display("test registers done");
        for (int p = 0; p < 2; p++)
            for (int e = 0; e < 5; e++)
            begin
                axi_wr(12'h400 + 12'(p * 256 + 4 * e), {16'hFFFF, rent[p][e]}, 4'hF, RESP_OKAY);
                axi_wr(12'h600 + 12'(p * 256 + 4 * e), {16'h0000, rent[p][e]}, 4'hF, RESP_OKAY);
            end
        axi_rd(12'h400, {RESP_OKAY, 32'h00000082});
        axi_wr(ADDR_CTRL, 32'hFFFF010F, 4'h3, RESP_OKAY);
        axi_rd(ADDR_CTRL, {RESP_OKAY, 32'h0000010F});
        $display("test routing done");
        fork
            frame(0, 1'h1, 99);
            begin
                #230;
                frame(1, 1'h1, 99);
            end
        join
        frame(0, 1'h0, 4);
        frame(0, 1'h1, 2);
        $display("test frames done");
        @(posedge aclk);
        dchan_pending <= 2'h3;
        repeat (3) @(posedge aclk);
        cmp(link_out[0].dchan_tx_request, 1'h1);
        cmp(link_out[1].dchan_tx_request, 1'h0);
        axi_rd(ADDR_STATUS, {RESP_OKAY, 32'h00002143});
        dchan_pending <= 2'h0;
        repeat (3) @(posedge aclk);
        cmp(link_out[0].dchan_tx_request, 1'h0);
        cmp(rd_q.size() + wr_q.size(), 0);
        $display("test request done");
        wrap_up();
    end

    // hang guard, well beyond the few frames of the run
    initial
    begin
        #200000;
        n_fail++;
        wrap_up();
    end
endmodule
